// [rspc_top.sv]
// pin state control for reset, standby and bus release
// assumes the core reports its bus state each CORE_CLK cycle
`include "rspc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module rspc_top #(
    parameter int ADDR_W = 24,
    parameter int DATA_W = 16,
    parameter int PORT_W = 8,
    parameter int CS_W = 4
) (
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic EXTERNAL_CLEAR_N,
    input wire logic LOW_POWER_REQUEST_N,
    input wire logic BUS_REQ_N,
    input wire logic [2:0] MODE,
    input wire logic SW_STANDBY,
    input wire rspc_pkg::rspc_bus_t BUS_STATE,
    input wire logic TWO_STATE_AREA,
    input wire logic [ADDR_W-1:0] CORE_ADDR,
    input wire logic [DATA_W-1:0] CORE_DATA,
    input wire logic CORE_DATA_OE,
    input wire rspc_pkg::rspc_strobe_t CORE_STROBE,
    input wire logic [CS_W-1:0] CORE_CS_N,
    input wire logic [PORT_W-1:0] CORE_PORT_OUT,
    input wire logic [PORT_W-1:0] CORE_PORT_DIR,
    output logic [ADDR_W-1:0] ADDR_O,
    output logic ADDR_OE,
    output logic UPPER_ADDR_OE,
    output logic [DATA_W-1:0] DATA_O,
    output logic DATA_OE,
    output rspc_pkg::rspc_strobe_t STROBE_O,
    output logic STROBE_OE,
    output logic [CS_W-1:0] CS_N_O,
    output logic CS_OE,
    output logic [PORT_W-1:0] PORT_O,
    output logic [PORT_W-1:0] PORT_OE,
    output logic BUS_GRANT,
    output logic IN_RESET
);
    initial begin
        if (ADDR_W < 5 || DATA_W < 8 || CS_W < 1 || PORT_W < 1) begin
            $error("rspc_top: unsupported width");
        end
    end

    // ---------------------------------------------------------------
    // synchronisers; reset is sampled on the falling clock edge
    // ---------------------------------------------------------------
    logic clr_s1_r, clr_s2_r, low_power_request_n_s1_r, low_power_request_n_s2_r, breq_s1_r, breq_s2_r;
    always_ff @(negedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            clr_s1_r <= 1'b1;
            clr_s2_r <= 1'b1;
        end else begin
            clr_s1_r <= EXTERNAL_CLEAR_N;
            clr_s2_r <= clr_s1_r;
        end
    end
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            low_power_request_n_s1_r <= 1'b1;
            low_power_request_n_s2_r <= 1'b1;
            breq_s1_r <= 1'b1;
            breq_s2_r <= 1'b1;
        end else begin
            low_power_request_n_s1_r <= LOW_POWER_REQUEST_N;
            low_power_request_n_s2_r <= low_power_request_n_s1_r;
            breq_s1_r <= BUS_REQ_N;
            breq_s2_r <= breq_s1_r;
        end
    end

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    function automatic logic mode_expanded_hi(input logic [2:0] m);
        return (m == 3'h3) || (m == 3'h4) || (m == 3'h6);
    endfunction

    wire logic rst_now = !clr_s2_r;
    wire logic hw_low_power_request_n = !low_power_request_n_s2_r;
    wire logic single_chip = (MODE == `RSPC_MODE_SINGLE);
    wire logic grant_ok = !single_chip && !breq_s2_r && !rst_now;
    wire logic hold = SW_STANDBY || BUS_GRANT;
    wire logic exp_hi = mode_expanded_hi(MODE);
    // address kept in T3, in two-state T2; cleared in T1, T2, TW
    wire logic addr_keep = (BUS_STATE == rspc_pkg::RSPC_T3) ||
        (TWO_STATE_AREA && BUS_STATE == rspc_pkg::RSPC_T2);
    wire rspc_pkg::rspc_strobe_t strobe_idle = '{1'b1, 1'b1, 1'b1, 1'b1};

    // ---------------------------------------------------------------
    // reset tracking: address clears half a state after sampling
    // ---------------------------------------------------------------
    logic rst_r, keep_r;
    logic rst_nxt, keep_nxt;
    assign rst_nxt = rst_now;
    // keep latches at reset entry and lasts while the state stays T2 or T3
    assign keep_nxt = rst_now && (rst_r ? keep_r &&
        (BUS_STATE == rspc_pkg::RSPC_T3 || BUS_STATE == rspc_pkg::RSPC_T2)
        : addr_keep);
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_r <= 1'b0;
            keep_r <= 1'b0;
        end else begin
            rst_r <= rst_nxt;
            keep_r <= keep_nxt;
        end
    end

    // ---------------------------------------------------------------
    // pin drive
    // ---------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ADDR_O <= ADDR_W'(`RSPC_ADDR_RST);
            ADDR_OE <= 1'b1;
            UPPER_ADDR_OE <= 1'b0;
            DATA_O <= '0;
            DATA_OE <= 1'b0;
            STROBE_O <= '{1'b1, 1'b1, 1'b1, 1'b1};
            STROBE_OE <= 1'b1;
            CS_N_O <= '1;
            CS_OE <= 1'b0;
            PORT_O <= '0;
            PORT_OE <= '0;
            BUS_GRANT <= 1'b0;
            IN_RESET <= 1'b1;
        end else if (hw_low_power_request_n) begin
            ADDR_OE <= 1'b0;
            UPPER_ADDR_OE <= 1'b0;
            DATA_OE <= 1'b0;
            STROBE_OE <= 1'b0;
            CS_OE <= 1'b0;
            PORT_OE <= '0;
            BUS_GRANT <= 1'b0;
            IN_RESET <= rst_now;
        end else if (rst_now) begin
            PORT_OE <= '0;
            STROBE_O <= strobe_idle;
            STROBE_OE <= 1'b1;
            DATA_OE <= 1'b0;
            CS_OE <= 1'b0;
            BUS_GRANT <= 1'b0;
            IN_RESET <= 1'b1;
            ADDR_OE <= 1'b1;
            if (!(rst_r ? keep_r : addr_keep)) begin
                ADDR_O <= ADDR_W'(`RSPC_ADDR_RST);
            end
        end else if (hold) begin
            // inputs and data float; address and strobes are driven, or float once the bus is granted;
            // in modes 3, 4 and 6 chip selects go high and upper address floats; other outputs keep their last level
            PORT_OE <= PORT_OE & CORE_PORT_DIR;
            DATA_OE <= 1'b0;
            STROBE_OE <= !BUS_GRANT;
            CS_N_O <= exp_hi ? '1 : CS_N_O;
            UPPER_ADDR_OE <= exp_hi ? 1'b0 : UPPER_ADDR_OE;
            ADDR_OE <= !BUS_GRANT;
            BUS_GRANT <= grant_ok;
            IN_RESET <= 1'b0;
        end else begin
            ADDR_O <= CORE_ADDR;
            ADDR_OE <= !single_chip;
            UPPER_ADDR_OE <= exp_hi;
            DATA_O <= CORE_DATA;
            DATA_OE <= CORE_DATA_OE && !single_chip;
            STROBE_O <= CORE_STROBE;
            STROBE_OE <= !single_chip;
            CS_N_O <= CORE_CS_N;
            CS_OE <= exp_hi;
            PORT_O <= CORE_PORT_OUT;
            PORT_OE <= CORE_PORT_DIR;
            BUS_GRANT <= grant_ok;
            IN_RESET <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_rst_rise;
        !rst_r && rst_now;
    endsequence
    chk_reset_ports_in: assert property (@(posedge CORE_CLK)
        disable iff (!ARST_N) rst_now |=> PORT_OE == '0)
        else $error("ports not released on reset");
    chk_reset_strobes_high: assert property (@(posedge CORE_CLK)
        disable iff (!ARST_N) rst_now && !hw_low_power_request_n |=>
        STROBE_O == strobe_idle && !DATA_OE)
        else $error("strobes or data wrong in reset");
    chk_addr_clear_t1: assert property (@(posedge CORE_CLK)
        disable iff (!ARST_N) s_rst_rise ##0 !addr_keep ##0 !hw_low_power_request_n
        |=> ADDR_O == '0)
        else $error("address not cleared after reset in T1/T2");
    chk_addr_hold_t3: assert property (@(posedge CORE_CLK)
        disable iff (!ARST_N) s_rst_rise ##0
        (BUS_STATE == rspc_pkg::RSPC_T3) ##0 !hw_low_power_request_n
        |=> ADDR_O == $past(ADDR_O))
        else $error("address not held in T3 reset");
    chk_addr_hold_two: assert property (@(posedge CORE_CLK)
        disable iff (!ARST_N) s_rst_rise ##0 TWO_STATE_AREA ##0
        (BUS_STATE == rspc_pkg::RSPC_T2) ##0 !hw_low_power_request_n
        |=> ADDR_O == $past(ADDR_O))
        else $error("address not held in two-state T2 reset");
    chk_addr_clear_tw: assert property (@(posedge CORE_CLK)
        disable iff (!ARST_N) s_rst_rise ##0
        (BUS_STATE == rspc_pkg::RSPC_TW) ##0 !hw_low_power_request_n |=> ADDR_O == '0)
        else $error("address not cleared in wait-state reset");
    chk_mode7_no_grant: assert property (@(posedge CORE_CLK)
        disable iff (!ARST_N) single_chip [*2] |-> !BUS_GRANT)
        else $error("bus granted in single-chip mode");
    chk_hold_data_float: assert property (@(posedge CORE_CLK)
        disable iff (!ARST_N) hold && !rst_now && !hw_low_power_request_n |=>
        !DATA_OE && (PORT_OE & ~$past(PORT_OE)) == '0)
        else $error("hold condition drives new pins");
    chk_expand_cs_high: assert property (@(posedge CORE_CLK)
        disable iff (!ARST_N) hold && exp_hi && !rst_now && !hw_low_power_request_n
        |=> CS_N_O == '1 && !UPPER_ADDR_OE)
        else $error("chip selects not high in hold");
    chk_hw_standby_float: assert property (@(posedge CORE_CLK)
        disable iff (!ARST_N) hw_low_power_request_n |=>
        !ADDR_OE && !DATA_OE && !STROBE_OE && !CS_OE && PORT_OE == '0)
        else $error("pins driven in hardware standby");
endmodule // rspc_top
`default_nettype wire

// [rspc_defines.svh]
// timing counts, mode code and reset address for the reset/standby pin control block
// assumes CORE_CLK at 40 MHz
`ifndef RSPC_DEFINES_SVH
`define RSPC_DEFINES_SVH
`define RSPC_CLK_PERIOD_NS 25
`define RSPC_LOW_POWER_REQUEST_N_LEAD_CYC 10
`define RSPC_WAKE_LEAD_NS 100
`define RSPC_WAKE_LEAD_CYC ((`RSPC_WAKE_LEAD_NS + `RSPC_CLK_PERIOD_NS - 1) / `RSPC_CLK_PERIOD_NS)
`define RSPC_MODE_SINGLE 3'h7
`define RSPC_ADDR_RST 24'h000000
`endif

// [rspc_pkg.sv]
// types shared by the reset/standby pin control block
// assumes the defines header is compiled alongside
`default_nettype none
package rspc_pkg;
    // bus state of the access in progress
    typedef enum logic [2:0] {RSPC_IDLE, RSPC_T1, RSPC_T2, RSPC_T3,
        RSPC_TW} rspc_bus_t;
    // strobe group, all active low
    typedef struct packed {
        logic as_n;
        logic rd_n;
        logic upper_write_n;
        logic lower_write_n;
    } rspc_strobe_t;
endpackage
`default_nettype wire

// [rspc_supervisor.sv]
// supervisor model: drives the clear and low-power request pins
// assumes the bench's CORE_CLK; pins move just after rising edges
`include "rspc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module rspc_supervisor (
    input wire logic CORE_CLK,
    output logic EXTERNAL_CLEAR_N,
    output logic LOW_POWER_REQUEST_N
);
    initial begin
        EXTERNAL_CLEAR_N = 1'b1;
        LOW_POWER_REQUEST_N = 1'b1;
    end
    task automatic clear(input logic lvl);
        @(posedge CORE_CLK);
        EXTERNAL_CLEAR_N <= lvl;
    endtask
    // clear is let go in the same step as standby falls: zero spacing
    task automatic sleep(input logic keep_ram);
        if (keep_ram) begin
            clear(1'b0);
            repeat (`RSPC_LOW_POWER_REQUEST_N_LEAD_CYC) @(posedge CORE_CLK);
        end else begin
            @(posedge CORE_CLK);
        end
        LOW_POWER_REQUEST_N <= 1'b0;
        EXTERNAL_CLEAR_N <= 1'b1;
    endtask
    task automatic wake();
        clear(1'b0);
        repeat (`RSPC_WAKE_LEAD_CYC) @(posedge CORE_CLK);
        LOW_POWER_REQUEST_N <= 1'b1;
        repeat (4) @(posedge CORE_CLK);
        EXTERNAL_CLEAR_N <= 1'b1;
    endtask
endmodule // rspc_supervisor
`default_nettype wire

// [testbench.sv]
// self-checking bench for the reset/standby pin control block
// assumes rspc_pkg, the defines header and the supervisor model
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic [7:0] m;
        logic [7:0] f;
        logic ua;
        logic [23:0] a;
    } rspc_note_t;
    logic CORE_CLK = 0, ARST_N = 0, BUS_REQ_N = 1, SW_STANDBY = 0;
    logic TWO_STATE_AREA = 0, CORE_DATA_OE = 1;
    logic [2:0] MODE = 3'h3;
    rspc_pkg::rspc_bus_t BUS_STATE = rspc_pkg::RSPC_IDLE;
    rspc_pkg::rspc_strobe_t CORE_STROBE = 4'h0, STROBE_O;
    logic [23:0] CORE_ADDR = 24'h0, ADDR_O;
    logic [15:0] CORE_DATA = 16'hA5C3, DATA_O;
    logic [3:0] CORE_CS_N = 4'h0, CS_N_O;
    logic [7:0] CORE_PORT_OUT = 8'h5A, CORE_PORT_DIR = 8'hFF;
    logic [7:0] PORT_O, PORT_OE;
    logic ADDR_OE, UPPER_ADDR_OE, DATA_OE, STROBE_OE, CS_OE;
    logic BUS_GRANT, IN_RESET;
    wire EXTERNAL_CLEAR_N, LOW_POWER_REQUEST_N;
    rspc_note_t notes[$];
    event hit;
    int n_mismatch = 0, samples_checked = 0, cyc = 0, seed = 31621;
    rspc_pkg::rspc_bus_t st_tab[5] = '{rspc_pkg::RSPC_T1,
        rspc_pkg::RSPC_T2, rspc_pkg::RSPC_TW, rspc_pkg::RSPC_T3,
        rspc_pkg::RSPC_T2};

    rspc_top rspc_top_i (.CORE_CLK, .ARST_N, .EXTERNAL_CLEAR_N,
        .LOW_POWER_REQUEST_N, .BUS_REQ_N, .MODE, .SW_STANDBY, .BUS_STATE,
        .TWO_STATE_AREA, .CORE_ADDR, .CORE_DATA, .CORE_DATA_OE,
        .CORE_STROBE, .CORE_CS_N, .CORE_PORT_OUT, .CORE_PORT_DIR, .ADDR_O,
        .ADDR_OE, .UPPER_ADDR_OE, .DATA_O, .DATA_OE, .STROBE_O, .STROBE_OE,
        .CS_N_O, .CS_OE, .PORT_O, .PORT_OE, .BUS_GRANT, .IN_RESET);
    rspc_supervisor rspc_supervisor_i (.CORE_CLK, .EXTERNAL_CLEAR_N,
        .LOW_POWER_REQUEST_N);

    initial begin
        forever #12.5 CORE_CLK = ~CORE_CLK;
    end
    task automatic summarize();
        $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // hang guard: whole run needs well under a thousand cycles
    always @(posedge CORE_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic compare(input logic [35:0] got, input logic [35:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // results are read at the falling edge, well clear of the launch edge
    always @(hit) begin
        rspc_note_t n;
        logic [7:0] fl;
        n = notes.pop_front();
        fl = {ADDR_OE, UPPER_ADDR_OE, DATA_OE, STROBE_OE, CS_OE,
            |PORT_OE, BUS_GRANT, IN_RESET};
        compare({fl & n.m, n.ua ? {ADDR_O, STROBE_O} : 28'h0},
            {n.f & n.m, n.ua ? {n.a, 4'hF} : 28'h0});
    end
    task automatic note(input logic [7:0] m, input logic [7:0] f,
        input logic ua, input logic [23:0] a);
        notes.push_back('{m, f, ua, a});
        ->hit;
    endtask
    task automatic wait_rst(input logic lvl);
        for (int k = 0; k < 10 && IN_RESET !== lvl; k++) @(negedge CORE_CLK);
    endtask
    task automatic probe_after(input int n);
        repeat (n) @(negedge CORE_CLK);
    endtask

    initial begin
        logic [31:0] r;
        probe_after(2);
        note(8'hBF, 8'h91, 1'b1, 24'h0);
        repeat (3) @(posedge CORE_CLK);
        ARST_N <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            @(posedge CORE_CLK);
            r = $random(seed);
            CORE_ADDR <= r[23:0];
            CORE_PORT_OUT <= r[31:24];
            BUS_STATE <= st_tab[i];
            TWO_STATE_AREA <= (i == 4);
            rspc_supervisor_i.clear(1'b0);
            wait_rst(1'b1);
            note(8'hB7, 8'h91, 1'b1, (i > 2) ? r[23:0] : 24'h0);
            rspc_supervisor_i.clear(1'b1);
            BUS_STATE <= rspc_pkg::RSPC_IDLE;
            wait_rst(1'b0);
        end
        BUS_REQ_N <= 1'b0;
        probe_after(5);
        note(8'hF2, 8'h02, 1'b0, 24'h0);
        @(posedge CORE_CLK);
        BUS_REQ_N <= 1'b1;
        probe_after(5);
        @(posedge CORE_CLK);
        SW_STANDBY <= 1'b1;
        probe_after(3);
        note(8'hFF, 8'h9C, 1'b0, 24'h0);
        @(posedge CORE_CLK);
        SW_STANDBY <= 1'b0;
        MODE <= 3'h7;
        probe_after(5);
        BUS_REQ_N <= 1'b0;
        probe_after(5);
        note(8'h02, 8'h00, 1'b0, 24'h0);
        for (int j = 0; j < 2; j++) begin
            rspc_supervisor_i.sleep(j == 0);
            probe_after(5);
            note(8'hFC, 8'h00, 1'b0, 24'h0);
            rspc_supervisor_i.wake();
            probe_after(5);
        end
        summarize();
    end
endmodule // testbench
`default_nettype wire
